// >>> hw/branch_increment_exec.sv
// execution of decrement/increment and relative/indirect branch instructions
// What this block does
// - decrement-branch-nonzero wraps 00 to ff, branches if result nonzero, no flags.
// - its target is advanced program counter plus signed last-byte displacement.
// - register form is 11011rrr plus displacement, 2 bytes, 2 cycles.
// - decrement/increment on a port read the output latch, not pins.
// - byte increment on accumulator, register, direct, indirect wraps ff to 00.
// - data pointer increment is 16-bit, no flags, 1 byte, 2 cycles.
// - branch-bit-set branches on bit one to pc+3+displacement, bit unchanged.
// - branch-bit-set opcode 00100000, bit address then displacement, 2 cycles.
// - branch-and-clear clears a set bit and branches; zero bit untouched.
// - branch-and-clear on a port bit reads the output latch.
// - branch-carry-set branches on carry one to pc+2+displacement, 2 cycles.
// - indirect jump loads accumulator plus data pointer modulo 65536, opcode 73.
// - indirect jump leaves accumulator, data pointer and flags alone.
// - branch-bit-clear opcode 00110000 branches on bit zero to pc+3+displacement.
// - branch-carry-clear opcode 01010000 branches on carry zero to pc+2+disp.
// - branch-acc-nonzero opcode 01110000 branches when accumulator nonzero.
`timescale 1ns/1ps
module branch_increment_exec
	import branch_increment_pkg::*;
(
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic issue_in,
	input wire logic [7:0] opcode_in,
	input wire logic [7:0] byte2_in,
	input wire logic [7:0] byte3_in,
	input wire logic [7:0] operand_in,
	input wire logic operand_is_port_in,
	input wire logic [7:0] port_latch_in,
	input wire logic bit_value_in,
	input wire logic bit_is_port_in,
	input wire logic bit_latch_in,
	input wire logic carry_in,
	output logic busy_out,
	output logic done_out,
	output logic [15:0] pc_out,
	output logic [7:0] acc_out,
	output logic [15:0] data_pointer_out,
	output logic result_we_out,
	output logic [7:0] result_out,
	output logic bit_clear_out,
	output logic illegal_out
);
	// control state
	exec_state_t state_r;
	exec_state_t state_nxt;
	// architectural registers
	logic [15:0] pc_r;
	logic [15:0] pc_nxt;
	logic [7:0] acc_r;
	logic [7:0] acc_nxt;
	logic [15:0] dp_r;
	logic [15:0] dp_nxt;
	// status and one-cycle pulses
	logic busy_r;
	logic done_r;
	logic done_nxt;
	logic we_r;
	logic we_nxt;
	// result byte to write back
	logic [7:0] res_r;
	logic [7:0] res_nxt;
	logic bclr_r;
	logic bclr_nxt;
	logic ill_r;
	logic ill_nxt;

	// sign extension of a relative displacement
	function automatic logic [15:0] sign_ext8(input logic [7:0] disp);
		sign_ext8 = {{8{disp[7]}}, disp};
	endfunction

	// advanced program counter plus displacement, 16-bit wrap
	function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [15:0] len,
		input logic [7:0] disp);
		rel_target = pc + len + sign_ext8(disp);
	endfunction

	// byte add and subtract by one, wrapping at the byte boundary
	function automatic logic [7:0] plus_one8(input logic [7:0] v);
		plus_one8 = v + BYTE_ONE;
	endfunction

	function automatic logic [7:0] minus_one8(input logic [7:0] v);
		minus_one8 = v - BYTE_ONE;
	endfunction

	// 16-bit step of the program counter or data pointer, modulo 65536
	function automatic logic [15:0] step16(input logic [15:0] v, input logic [15:0] len);
		step16 = v + len;
	endfunction

	// decrement-branch forms
	wire is_dec_br_reg = (opcode_in & OP_DEC_BR_REG_MASK) == OP_DEC_BR_REG;
	wire is_dec_br_dir = opcode_in == OP_DEC_BR_DIR;

	// increment forms
	wire is_inc_acc = opcode_in == OP_INC_ACC;
	wire is_inc_dir = opcode_in == OP_INC_DIR;
	wire is_inc_ind = (opcode_in & OP_INC_IND_MASK) == OP_INC_IND;
	wire is_inc_reg = (opcode_in & OP_INC_REG_MASK) == OP_INC_REG;
	wire is_inc_dp = opcode_in == OP_INC_DP;

	// branch forms
	wire is_bset = opcode_in == OP_BIT_SET;
	wire is_bclr_br = opcode_in == OP_BIT_CLR_BR;
	wire is_bclear = opcode_in == OP_BIT_CLEAR;
	wire is_cset = opcode_in == OP_CARRY_SET;
	wire is_cclr = opcode_in == OP_CARRY_CLEAR;
	wire is_anz = opcode_in == OP_ACC_NONZERO;
	wire is_ijmp = opcode_in == OP_IND_JUMP;

	// grouped classes
	wire is_dec_br = is_dec_br_reg | is_dec_br_dir;
	wire is_inc_mem = is_inc_dir | is_inc_ind | is_inc_reg;
	wire known = is_dec_br | is_inc_acc | is_inc_mem | is_inc_dp | is_bset | is_bclr_br |
		is_bclear | is_cset | is_cclr | is_anz | is_ijmp;
	// only the acc and memory increments and unknown opcodes finish in one cycle
	wire two_cycle = known & ~is_inc_acc & ~is_inc_mem;

	// original value from the output latch when the operand is a port
	wire [7:0] orig_val = operand_is_port_in ? port_latch_in : operand_in;
	wire orig_bit = bit_is_port_in ? bit_latch_in : bit_value_in;
	wire [7:0] dec_val = minus_one8(orig_val);
	wire [7:0] inc_val = plus_one8(orig_val);
	wire [7:0] acc_inc = plus_one8(acc_r);
	wire [15:0] dp_inc = step16(dp_r, LEN_ONE);

	// targets and sequential addresses
	wire [7:0] dec_disp = is_dec_br_reg ? byte2_in : byte3_in;
	wire [15:0] dec_len = is_dec_br_reg ? LEN_TWO : LEN_THREE;
	wire [15:0] dec_tgt = rel_target(pc_r, dec_len, dec_disp);
	wire [15:0] bit_tgt = rel_target(pc_r, LEN_THREE, byte3_in);
	wire [15:0] short_tgt = rel_target(pc_r, LEN_TWO, byte2_in);
	wire [15:0] ijmp_tgt = {8'h00, acc_r} + dp_r;
	wire [15:0] pc_seq1 = step16(pc_r, LEN_ONE);
	wire [15:0] pc_seq2 = step16(pc_r, LEN_TWO);
	wire [15:0] pc_seq3 = step16(pc_r, LEN_THREE);
	wire [15:0] dec_seq = step16(pc_r, dec_len);

	// branch conditions, one per conditional form
	wire dec_taken = dec_val != 8'h00;
	wire bset_taken = orig_bit;
	wire bclr_br_taken = orig_bit;
	wire bclear_taken = ~orig_bit;
	wire cset_taken = carry_in;
	wire cclr_taken = ~carry_in;
	wire anz_taken = acc_r != 8'h00;

	// next program counter for each conditional form and the memory increments
	wire [15:0] dec_pc = dec_taken ? dec_tgt : dec_seq;
	wire [15:0] bset_pc = bset_taken ? bit_tgt : pc_seq3;
	wire [15:0] bclr_br_pc = bclr_br_taken ? bit_tgt : pc_seq3;
	wire [15:0] bclear_pc = bclear_taken ? bit_tgt : pc_seq3;
	wire [15:0] cset_pc = cset_taken ? short_tgt : pc_seq2;
	wire [15:0] cclr_pc = cclr_taken ? short_tgt : pc_seq2;
	wire [15:0] anz_pc = anz_taken ? short_tgt : pc_seq2;
	wire [15:0] inc_mem_pc = is_inc_dir ? pc_seq2 : pc_seq1;

	always_comb begin
		// defaults: hold registers, pulses low
		state_nxt = state_r;
		pc_nxt = pc_r;
		acc_nxt = acc_r;
		dp_nxt = dp_r;
		done_nxt = 1'b0;
		we_nxt = 1'b0;
		res_nxt = res_r;
		bclr_nxt = 1'b0;
		ill_nxt = 1'b0;
		// issue is only looked at in idle; the wait state refuses it
		unique case (state_r)
			ST_IDLE: begin
				if (issue_in) begin
					ill_nxt = ~known;
					done_nxt = ~two_cycle;
					if (two_cycle) begin
						state_nxt = ST_WAIT;
					end
					if (is_dec_br) begin
						we_nxt = 1'b1;
						res_nxt = dec_val;
						pc_nxt = dec_pc;
					end else if (is_inc_acc) begin
						acc_nxt = acc_inc;
						pc_nxt = pc_seq1;
					end else if (is_inc_mem) begin
						we_nxt = 1'b1;
						res_nxt = inc_val;
						pc_nxt = inc_mem_pc;
					end else if (is_inc_dp) begin
						dp_nxt = dp_inc;
						pc_nxt = pc_seq1;
					end else if (is_bset) begin
						pc_nxt = bset_pc;
					end else if (is_bclr_br) begin
						bclr_nxt = bclr_br_taken;
						pc_nxt = bclr_br_pc;
					end else if (is_bclear) begin
						pc_nxt = bclear_pc;
					end else if (is_cset) begin
						pc_nxt = cset_pc;
					end else if (is_cclr) begin
						pc_nxt = cclr_pc;
					end else if (is_anz) begin
						pc_nxt = anz_pc;
					end else if (is_ijmp) begin
						pc_nxt = ijmp_tgt;
					end else begin
						pc_nxt = pc_seq1;
					end
				end
			end
			// second cycle: finish and return to idle
			ST_WAIT: begin
				state_nxt = ST_IDLE;
				done_nxt = 1'b1;
			end
		endcase
	end

	// state register
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// program counter
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pc_r <= PC_RESET;
		end else begin
			pc_r <= pc_nxt;
		end
	end

	// accumulator
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			acc_r <= ACC_RESET;
		end else begin
			acc_r <= acc_nxt;
		end
	end

	// data pointer
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			dp_r <= DP_RESET;
		end else begin
			dp_r <= dp_nxt;
		end
	end

	// result byte
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			res_r <= 8'h00;
		end else begin
			res_r <= res_nxt;
		end
	end

	// busy mirrors the wait state
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			busy_r <= 1'b0;
		end else begin
			busy_r <= state_nxt == ST_WAIT;
		end
	end

	// completion and write pulses
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			done_r <= 1'b0;
			we_r <= 1'b0;
		end else begin
			done_r <= done_nxt;
			we_r <= we_nxt;
		end
	end

	// bit clear and illegal pulses
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			bclr_r <= 1'b0;
			ill_r <= 1'b0;
		end else begin
			bclr_r <= bclr_nxt;
			ill_r <= ill_nxt;
		end
	end

	// every output straight from a flop
	assign busy_out = busy_r;
	assign done_out = done_r;
	assign pc_out = pc_r;
	assign acc_out = acc_r;
	assign data_pointer_out = dp_r;
	assign result_we_out = we_r;
	assign result_out = res_r;
	assign bit_clear_out = bclr_r;
	assign illegal_out = ill_r;
endmodule

// >>> hw/branch_increment_pkg.sv
// constants for the branch and increment execution block
package branch_increment_pkg;
	localparam logic [7:0] OP_DEC_BR_REG_MASK = 8'hf8;
	localparam logic [7:0] OP_DEC_BR_REG = 8'hd8;
	localparam logic [7:0] OP_DEC_BR_DIR = 8'hd5;
	localparam logic [7:0] OP_INC_ACC = 8'h04;
	localparam logic [7:0] OP_INC_DIR = 8'h05;
	localparam logic [7:0] OP_INC_IND_MASK = 8'hfe;
	localparam logic [7:0] OP_INC_IND = 8'h06;
	localparam logic [7:0] OP_INC_REG_MASK = 8'hf8;
	localparam logic [7:0] OP_INC_REG = 8'h08;
	localparam logic [7:0] OP_INC_DP = 8'ha3;
	localparam logic [7:0] OP_BIT_SET = 8'h20;
	localparam logic [7:0] OP_BIT_CLR_BR = 8'h10;
	localparam logic [7:0] OP_BIT_CLEAR = 8'h30;
	localparam logic [7:0] OP_CARRY_SET = 8'h40;
	localparam logic [7:0] OP_CARRY_CLEAR = 8'h50;
	localparam logic [7:0] OP_ACC_NONZERO = 8'h70;
	localparam logic [7:0] OP_IND_JUMP = 8'h73;
	localparam logic [15:0] LEN_ONE = 16'h0001;
	localparam logic [15:0] LEN_TWO = 16'h0002;
	localparam logic [15:0] LEN_THREE = 16'h0003;
	localparam logic [1:0] CYCLES_ONE = 2'h1;
	localparam logic [1:0] CYCLES_TWO = 2'h2;
	localparam logic [7:0] BYTE_ONE = 8'h01;
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [15:0] DP_RESET = 16'h0000;
	localparam logic [7:0] ACC_RESET = 8'h00;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_WAIT = 2'b10
	} exec_state_t;
endpackage

// >>> tb/branch_increment_props.sv
// assertions for the branch and increment block
`timescale 1ns/1ps
module branch_increment_props
	import branch_increment_pkg::*;
(
	input wire logic clock_in, reset_n_in, issue_in, carry_in, busy_out, done_out,
	input wire logic bit_value_in, bit_is_port_in, bit_latch_in, bit_clear_out,
	input wire logic [7:0] opcode_in, byte2_in, byte3_in, acc_out,
	input wire logic [15:0] pc_out, data_pointer_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!reset_n_in);
	wire tk = issue_in && !busy_out;
	wire bv = bit_is_port_in ? bit_latch_in : bit_value_in;
	wire [15:0] n2 = pc_out + 16'h0002;
	wire [15:0] n3 = pc_out + 16'h0003;
	wire [15:0] t2 = n2 + {{8{byte2_in[7]}}, byte2_in};
	wire [15:0] t3 = n3 + {{8{byte3_in[7]}}, byte3_in};
	sequence two_cyc;
		busy_out && !done_out ##1 done_out && !busy_out;
	endsequence
	AST_TWO_CYC: assert property (tk && opcode_in == OP_BIT_SET |=> two_cyc)
		else $error("bit branch timing");
	AST_DEC_TWO_CYC: assert property (tk && (opcode_in & OP_DEC_BR_REG_MASK) == OP_DEC_BR_REG |=>
		two_cyc) else $error("decrement branch timing");
	AST_BIT_CLEAR_TGT: assert property (tk && opcode_in == OP_BIT_CLEAR |=>
		pc_out == ($past(bv) ? $past(n3) : $past(t3))) else $error("bit clear target");
	AST_BIT_SET_TGT: assert property (tk && opcode_in == OP_BIT_SET |=>
		pc_out == ($past(bv) ? $past(t3) : $past(n3))) else $error("bit set target");
	AST_BIT_CLR_PULSE: assert property (tk && opcode_in == OP_BIT_CLR_BR |=>
		bit_clear_out == $past(bv)) else $error("bit clear pulse");
	AST_CARRY_TGT: assert property (tk && opcode_in == OP_CARRY_SET |=>
		pc_out == ($past(carry_in) ? $past(t2) : $past(n2))) else $error("carry target");
	AST_ACC_NZ_TGT: assert property (tk && opcode_in == OP_ACC_NONZERO |=>
		pc_out == ($past(acc_out) != 8'h00 ? $past(t2) : $past(n2))) else $error("acc target");
	AST_IJMP: assert property (tk && opcode_in == OP_IND_JUMP |=>
		pc_out == {8'h00, $past(acc_out)} + $past(data_pointer_out)) else $error("jump target");
	AST_INCDP: assert property (tk && opcode_in == OP_INC_DP |=>
		data_pointer_out == $past(data_pointer_out) + 16'h0001 ##1 done_out) else $error("dp inc");
	AST_INCA: assert property (tk && opcode_in == OP_INC_ACC |=>
		acc_out == $past(acc_out) + 8'h01 && done_out) else $error("acc inc");
endmodule

// >>> tb/tb_branch_increment_exec.sv
// self-checking bench for the branch and increment block
`timescale 1ns/1ps
module tb_branch_increment_exec;
	import branch_increment_pkg::*;
	logic clock_in = 1'h0, reset_n_in = 1'h0, issue_in = 1'h0, operand_is_port_in = 1'h0;
	logic bit_value_in = 1'h0, bit_is_port_in = 1'h0, bit_latch_in = 1'h0, carry_in = 1'h0;
	logic [7:0] opcode_in = 8'h00, byte2_in = 8'h00, byte3_in = 8'h00;
	logic [7:0] operand_in = 8'h00, port_latch_in = 8'h00;
	logic [8:0] wr;
	logic clr;
	logic ill;
	logic [15:0] epc = 16'h0000;
	wire busy_out, done_out, result_we_out, bit_clear_out, illegal_out;
	wire [15:0] pc_out, data_pointer_out;
	wire [7:0] acc_out, result_out;
	int error_cnt = 0;
	int comparisons = 0;
	branch_increment_exec DUT (
		.clock_in(clock_in),
		.reset_n_in(reset_n_in),
		.issue_in(issue_in),
		.opcode_in(opcode_in),
		.byte2_in(byte2_in),
		.byte3_in(byte3_in),
		.operand_in(operand_in),
		.operand_is_port_in(operand_is_port_in),
		.port_latch_in(port_latch_in),
		.bit_value_in(bit_value_in),
		.bit_is_port_in(bit_is_port_in),
		.bit_latch_in(bit_latch_in),
		.carry_in(carry_in),
		.busy_out(busy_out),
		.done_out(done_out),
		.pc_out(pc_out),
		.acc_out(acc_out),
		.data_pointer_out(data_pointer_out),
		.result_we_out(result_we_out),
		.result_out(result_out),
		.bit_clear_out(bit_clear_out),
		.illegal_out(illegal_out)
	);
	initial begin
		forever #2 clock_in = ~clock_in;
	end
	task chk(input string n, input logic [23:0] e, input logic [23:0] s);
		comparisons++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task close_out;
		$display("mismatches %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task run(input logic [7:0] o, input logic [7:0] x2, input logic [7:0] x3);
		@(posedge clock_in);
		opcode_in <= o;
		byte2_in <= x2;
		byte3_in <= x3;
		issue_in <= 1'h1;
		@(posedge clock_in);
		issue_in <= 1'h0;
		#1;
		wr = {result_we_out, result_out};
		clr = bit_clear_out;
		ill = illegal_out;
		for (int i = 0; i < 4 && done_out !== 1'h1; i++) begin
			@(posedge clock_in);
			#1;
		end
		if (done_out !== 1'h1) begin
			error_cnt++;
			close_out();
		end
	endtask
	task br(input logic [7:0] o, x2, x3, input logic t, input logic [15:0] len);
		logic [7:0] d;
		d = (len == LEN_TWO) ? x2 : x3;
		run(o, x2, x3);
		epc = epc + len + (t ? {{8{d[7]}}, d} : 16'h0000);
		chk("pc", epc, pc_out);
	endtask
	task t_dec_branch;
		operand_in <= 8'h01;
		br(OP_DEC_BR_REG | 8'h03, 8'hfe, 8'h00, 1'h0, LEN_TWO);
		chk("dec", 24'h000100, wr);
		operand_in <= 8'h00;
		br(OP_DEC_BR_REG, 8'h80, 8'h00, 1'h1, LEN_TWO);
		chk("dec", 24'h0001ff, wr);
		operand_is_port_in <= 1'h1;
		port_latch_in <= 8'h05;
		br(OP_DEC_BR_DIR, 8'h40, 8'h7f, 1'h1, LEN_THREE);
		chk("dec", 24'h000104, wr);
	endtask
	task t_inc;
		port_latch_in <= 8'hff;
		br(OP_INC_DIR, 8'h90, 8'h00, 1'h0, LEN_TWO);
		chk("inc", 24'h000100, wr);
		operand_is_port_in <= 1'h0;
		operand_in <= 8'h7f;
		br(OP_INC_REG | 8'h05, 8'h00, 8'h00, 1'h0, LEN_ONE);
		chk("inc reg", 24'h000180, wr);
		operand_in <= 8'hff;
		br(OP_INC_IND | 8'h01, 8'h00, 8'h00, 1'h0, LEN_ONE);
		chk("inc ind", 24'h000100, wr);
		br(OP_ACC_NONZERO, 8'h55, 8'h00, 1'h0, LEN_TWO);
		br(OP_INC_ACC, 8'h00, 8'h00, 1'h0, LEN_ONE);
		chk("acc", 24'h000001, acc_out);
	endtask
	task t_carry;
		for (int c = 0; c < 2; c++) begin
			carry_in <= c[0];
			br(OP_CARRY_SET, 8'h10, 8'h00, c[0], LEN_TWO);
			br(OP_CARRY_CLEAR, 8'hf0, 8'h00, !c[0], LEN_TWO);
		end
	endtask
	task t_bits;
		for (int b = 0; b < 2; b++) begin
			bit_value_in <= b[0];
			br(OP_BIT_SET, 8'h21, 8'h08, b[0], LEN_THREE);
			br(OP_BIT_CLEAR, 8'h21, 8'hf8, !b[0], LEN_THREE);
			br(OP_BIT_CLR_BR, 8'h21, 8'h04, b[0], LEN_THREE);
			chk("clr", {23'h000000, b[0]}, clr);
		end
		bit_is_port_in <= 1'h1;
		bit_latch_in <= 1'h1;
		bit_value_in <= 1'h0;
		br(OP_BIT_CLR_BR, 8'h90, 8'h02, 1'h1, LEN_THREE);
		chk("clr", 24'h000001, clr);
	endtask
	task t_ptr;
		repeat (255) br(OP_INC_DP, 8'h00, 8'h00, 1'h0, LEN_ONE);
		chk("dp", 24'h0000ff, data_pointer_out);
		run(OP_IND_JUMP, 8'h00, 8'h00);
		epc = 16'h0100;
		chk("pc", epc, pc_out);
		chk("acc dp", 24'h0100ff, {acc_out, data_pointer_out});
		br(OP_ACC_NONZERO, 8'h7e, 8'h00, 1'h1, LEN_TWO);
		br(OP_INC_DP, 8'h00, 8'h00, 1'h0, LEN_ONE);
		chk("dp", 24'h000100, data_pointer_out);
		chk("legal", 24'h000000, ill);
		br(8'h00, 8'h00, 8'h00, 1'h0, LEN_ONE);
		chk("illegal", 24'h000001, ill);
	endtask
	initial begin
		repeat (16) @(posedge clock_in);
		reset_n_in <= 1'h1;
		t_dec_branch();
		t_inc();
		t_carry();
		t_bits();
		t_ptr();
		close_out();
	end
endmodule
bind branch_increment_exec branch_increment_props props_i (
	.clock_in(clock_in),
	.reset_n_in(reset_n_in),
	.issue_in(issue_in),
	.carry_in(carry_in),
	.busy_out(busy_out),
	.done_out(done_out),
	.bit_value_in(bit_value_in),
	.bit_is_port_in(bit_is_port_in),
	.bit_latch_in(bit_latch_in),
	.bit_clear_out(bit_clear_out),
	.opcode_in(opcode_in),
	.byte2_in(byte2_in),
	.byte3_in(byte3_in),
	.acc_out(acc_out),
	.pc_out(pc_out),
	.data_pointer_out(data_pointer_out)
);
